/* File: design/cmr_pin_decode.sv */
`default_nettype none
module cmr_pin_decode (
    input wire logic [3:0] code,
    output logic [7:0] pin_sel
);
    // One-hot pin select; any code with the top bit set connects no pin.
    always_comb begin
        pin_sel = 8'h00;
        if (!code[cmr_pkg::MUX_NONE_BIT]) begin
            pin_sel[code[2:0]] = 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: design/cmr_regs.sv */
`default_nettype none
// Summary of operation
// - Mux bits 7-4 pick negative pin P0.1..P1.7; bit 7 set connects none.
// - Mux bits 3-0 pick positive pin P0.0..P1.6; bit 3 set connects none.
// - Mode bit 5 enables the rising-edge interrupt.
// - Mode bit 4 enables the falling-edge interrupt.
// - Mode bits 7-6 and 3-2 read zero and ignore writes.
// - Mode bits 1-0 drive the analog response-time mode, 0 fastest, 3 slowest.
// - A high-to-low change of the synchronised output sets the falling flag.
// - A low-to-high change of the synchronised output sets the rising flag.
// - Edge flags stay set until software clears them.
module cmr_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire cmr_pkg::cmr_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic cmp_raw,
    output var cmr_pkg::cmr_ana_ctl_s ana_ctl,
    output logic cmp_irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [7:0] mux;
        logic sync1;
        logic sync2;
        logic out_state;
        logic [7:0] rdata;
        logic irq;
        cmr_pkg::cmr_ana_ctl_s ana;
    } cmr_state_s;

    localparam cmr_state_s ST_RESET = '{ctrl: cmr_pkg::RST_CTRL, mode: cmr_pkg::RST_MODE,
        mux: cmr_pkg::RST_MUX, sync1: 1'b0, sync2: 1'b0, out_state: 1'b0, rdata: 8'h00,
        irq: 1'b0, ana: '{enable: 1'b0, response_mode: cmr_pkg::RST_MODE[1:0], pos_pin_sel: 8'h00,
        neg_pin_sel: 8'h00}};

    cmr_state_s st;
    cmr_state_s next_st;
    logic [7:0] pos_sel;
    logic [7:0] neg_sel;
    logic [7:0] next_mux;

    // ------------------------------------------------------------
    // Input pin decoders
    // ------------------------------------------------------------
    // Mux value that the coming edge will hold; taken apart from the state copy so that
    // the decoders do not form a loop through the next-state process.
    assign next_mux = (sfr_req.wr && sfr_req.addr == cmr_pkg::ADDR_MUX) ? sfr_req.wdata : st.mux;
    cmr_pin_decode u_neg (
        .code(next_mux[cmr_pkg::MUX_NEG_LSB +: 4]),
        .pin_sel(neg_sel)
    );
    cmr_pin_decode u_pos (
        .code(next_mux[cmr_pkg::MUX_POS_LSB +: 4]),
        .pin_sel(pos_sel)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Register writes, edge flags, read data and analog controls.
    always_comb begin
        logic rise;
        logic fall;
        logic [7:0] wr_ctrl;
        rise = 1'b0;
        fall = 1'b0;
        wr_ctrl = 8'h00;
        next_st = st;
        next_st.sync1 = cmp_raw;
        next_st.sync2 = st.sync1;
        next_st.out_state = st.sync2 & st.ctrl[cmr_pkg::CTRL_EN_BIT];
        rise = next_st.out_state & ~st.out_state;
        fall = ~next_st.out_state & st.out_state;
        if (sfr_req.wr) begin
            case (sfr_req.addr)
                cmr_pkg::ADDR_CTRL: begin
                    wr_ctrl = sfr_req.wdata;
                    next_st.ctrl = {wr_ctrl[7], 1'b0, wr_ctrl[5:0]};
                end
                cmr_pkg::ADDR_MODE: next_st.mode = sfr_req.wdata & cmr_pkg::MODE_WMASK;
                cmr_pkg::ADDR_MUX: next_st.mux = sfr_req.wdata;
                default: next_st.ctrl = st.ctrl;
            endcase
        end
        // sticky flags, set wins over software clear
        if (rise) begin
            next_st.ctrl[cmr_pkg::CTRL_RIF_BIT] = 1'b1;
        end
        if (fall) begin
            next_st.ctrl[cmr_pkg::CTRL_FIF_BIT] = 1'b1;
        end
        next_st.ctrl[cmr_pkg::CTRL_OUT_BIT] = 1'b0;
        // Read data reflects the live output bit in the control register.
        next_st.rdata = 8'h00;
        if (sfr_req.rd) begin
            case (sfr_req.addr)
                cmr_pkg::ADDR_CTRL: begin
                    next_st.rdata = st.ctrl;
                    next_st.rdata[cmr_pkg::CTRL_OUT_BIT] = st.out_state;
                end
                cmr_pkg::ADDR_MODE: next_st.rdata = st.mode;
                cmr_pkg::ADDR_MUX: next_st.rdata = st.mux;
                default: next_st.rdata = 8'h00;
            endcase
        end
        next_st.irq = (next_st.ctrl[cmr_pkg::CTRL_RIF_BIT] & next_st.mode[cmr_pkg::MODE_RIE_BIT])
            | (next_st.ctrl[cmr_pkg::CTRL_FIF_BIT] & next_st.mode[cmr_pkg::MODE_FIE_BIT]);
        next_st.ana.response_mode = next_st.mode[1:0];
        next_st.ana.enable = next_st.ctrl[cmr_pkg::CTRL_EN_BIT];
        next_st.ana.pos_pin_sel = pos_sel;
        next_st.ana.neg_pin_sel = neg_sel;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Holds all state; the clock enable freezes everything.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= ST_RESET;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign sfr_rdata = st.rdata;
    assign ana_ctl = st.ana;
    assign cmp_irq = st.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_mode_unused_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (st.mode & ~cmr_pkg::MODE_WMASK) == 8'h00) else $error("Unused mode bits not zero.");
    a_rise_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && st.out_state == 1'b0 && next_st.out_state |=> st.ctrl[cmr_pkg::CTRL_RIF_BIT])
        else $error("Rising edge did not set flag.");
    a_fall_flag_set: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && st.out_state && !next_st.out_state |=> st.ctrl[cmr_pkg::CTRL_FIF_BIT])
        else $error("Falling edge did not set flag.");
    a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
        st.ctrl[cmr_pkg::CTRL_RIF_BIT] && !(sfr_req.wr && sfr_req.addr == cmr_pkg::ADDR_CTRL)
        |=> st.ctrl[cmr_pkg::CTRL_RIF_BIT]) else $error("Rising flag dropped without clear.");
    a_disabled_low: assert property (@(posedge clk) disable iff (sys_rst)
        !st.ctrl[cmr_pkg::CTRL_EN_BIT] && clk_en |=> !st.out_state) else $error("Output high while off.");
    a_irq_rise_gate: assert property (@(posedge clk) disable iff (sys_rst)
        !st.mode[cmr_pkg::MODE_RIE_BIT] && !(st.ctrl[cmr_pkg::CTRL_FIF_BIT] && st.mode[cmr_pkg::MODE_FIE_BIT])
        |-> !st.irq) else $error("Rising flag raised an interrupt while masked.");
    a_irq_fall_gate: assert property (@(posedge clk) disable iff (sys_rst)
        st.mode[cmr_pkg::MODE_FIE_BIT] && st.ctrl[cmr_pkg::CTRL_FIF_BIT] |-> st.irq)
        else $error("Falling interrupt missing.");
    a_irq_combined: assert property (@(posedge clk) disable iff (sys_rst)
        st.irq == ((st.ctrl[cmr_pkg::CTRL_RIF_BIT] & st.mode[cmr_pkg::MODE_RIE_BIT])
        | (st.ctrl[cmr_pkg::CTRL_FIF_BIT] & st.mode[cmr_pkg::MODE_FIE_BIT]))) else $error("Interrupt mismatch.");
    a_mode_write_mask: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && sfr_req.wr && sfr_req.addr == cmr_pkg::ADDR_MODE
        |=> st.mode == ($past(sfr_req.wdata) & cmr_pkg::MODE_WMASK)) else $error("Mode write not masked.");
    a_enable_out: assert property (@(posedge clk) disable iff (sys_rst)
        st.ana.enable == st.ctrl[cmr_pkg::CTRL_EN_BIT]) else $error("Enable not passed on.");
    a_resp_mode: assert property (@(posedge clk) disable iff (sys_rst)
        st.ana.response_mode == st.mode[1:0]) else $error("Response mode not passed on.");
    a_neg_none: assert property (@(posedge clk) disable iff (sys_rst)
        st.mux[7] |-> st.ana.neg_pin_sel == 8'h00) else $error("Negative pin connected for none code.");
    a_pos_none: assert property (@(posedge clk) disable iff (sys_rst)
        st.mux[3] |-> st.ana.pos_pin_sel == 8'h00) else $error("Positive pin connected for none code.");
endmodule
`default_nettype wire

/* File: shared/cmr_pkg.sv */
`default_nettype none
package cmr_pkg;
    // Special-function addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h9b;
    localparam logic [7:0] ADDR_MODE = 8'h9d;
    localparam logic [7:0] ADDR_MUX = 8'h9f;
    // Reset values.
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h02;
    localparam logic [7:0] RST_MUX = 8'hff;
    // Control register fields.
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OUT_BIT = 6;
    localparam int CTRL_RIF_BIT = 5;
    localparam int CTRL_FIF_BIT = 4;
    // Mode register fields.
    localparam int MODE_RIE_BIT = 5;
    localparam int MODE_FIE_BIT = 4;
    localparam logic [7:0] MODE_WMASK = 8'h33;
    // Mux register fields.
    localparam int MUX_NEG_LSB = 4;
    localparam int MUX_POS_LSB = 0;
    localparam int MUX_NONE_BIT = 3;
    // Typical response times for modes 0 and 3, in ns.
    localparam int RESP_MODE0_NS = 100;
    localparam int RESP_MODE3_NS = 1050;
    localparam int CLK_PERIOD_NS = 4;
    localparam int RESP_MODE0_CYC = RESP_MODE0_NS / CLK_PERIOD_NS;
    localparam int RESP_MODE3_CYC = RESP_MODE3_NS / CLK_PERIOD_NS;

    // Special-function bus request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cmr_sfr_req_s;

    // Analog control outputs.
    typedef struct packed {
        logic enable;
        logic [1:0] response_mode;
        logic [7:0] pos_pin_sel;
        logic [7:0] neg_pin_sel;
    } cmr_ana_ctl_s;
endpackage
`default_nettype wire

/* File: tb/cmr_ana_model.sv */
`default_nettype none
// ----------------------------------------
// Analog comparator stand-in
// ----------------------------------------
module cmr_ana_model (
    input wire logic clk,
    input wire cmr_pkg::cmr_ana_ctl_s ana_ctl,
    input wire logic level,
    output logic cmp_raw
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    logic raw = 1'b0;
    assign cmp_raw = raw;
    // response mode delay
    // The raw output follows the level late, slower for a higher mode.
    always @(posedge clk) begin
        if (raw == level) begin
            cnt <= 0;
        end else if (cnt >= 2 * ana_ctl.response_mode) begin
            raw <= level;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`default_nettype none
// ----------------------------------------
// Register bank bench
// ----------------------------------------
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, level = 1'b0, rd_seen = 1'b0, cmp_raw, cmp_irq;
    logic [7:0] sfr_rdata, v, q[$];
    cmr_pkg::cmr_sfr_req_s req = '0;
    cmr_pkg::cmr_ana_ctl_s ana;
    int fails = 0, total_checks = 0, cyc = 0;
    always #2 clk = ~clk;
    cmr_regs DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .sfr_req(req), .sfr_rdata(sfr_rdata),
        .cmp_raw(cmp_raw), .ana_ctl(ana), .cmp_irq(cmp_irq));
    cmr_ana_model MDL (.clk(clk), .ana_ctl(ana), .level(level), .cmp_raw(cmp_raw));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One bus cycle, launched and released on falling edges.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk) req = '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        q.push_back(exp);
        acc(1'b0, a, 8'h00);
    endtask
    function automatic logic [7:0] oh(input logic [3:0] c);
        return c[3] ? 8'h00 : 8'h01 << c[2:0];
    endfunction
    // Read data lands one edge after the strobe; the oldest note is compared.
    always @(posedge clk) rd_seen <= req.rd & clk_en;
    always @(negedge clk) if (rd_seen) chk(sfr_rdata, q.pop_front());
    // The cycle ceiling cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end
    // Main sequence of tests.
    initial begin
        void'($urandom(60));
        repeat (8) @(posedge clk);
        @(negedge clk) sys_rst = 1'b0;
        rd(8'h9b, 8'h00);
        rd(8'h9d, 8'h02);
        rd(8'h9f, 8'hff);
        chk(ana.neg_pin_sel, 8'h00);
        chk(ana.pos_pin_sel, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            v = {i[3:0], ~i[3:0]};
            wr(8'h9f, v);
            chk(ana.neg_pin_sel, oh(v[7:4]));
            chk(ana.pos_pin_sel, oh(v[3:0]));
            rd(8'h9f, v);
        end
        $display("test input select done");
        for (int i = 0; i < 4; i++) begin
            v = (8'($urandom) & 8'hcc) | 8'(i);
            wr(8'h9d, v | 8'h30);
            chk({6'h00, ana.response_mode}, 8'(i));
            rd(8'h9d, (v & 8'h03) | 8'h30);
        end
        wr(8'h9e, 8'hff);
        rd(8'h9e, 8'h00);
        rd(8'h9d, (v & 8'h03) | 8'h30);
        $display("test mode done");
        wr(8'h9d, 8'h00);
        wr(8'h9b, 8'h80);
        chk({7'h00, ana.enable}, 8'h01);
        repeat (20) @(negedge clk);
        wr(8'h9b, 8'h80);
        level = 1'b1;
        repeat (20) @(negedge clk);
        rd(8'h9b, 8'he0);
        chk({7'h00, cmp_irq}, 8'h00);
        wr(8'h9d, 8'h20);
        chk({7'h00, cmp_irq}, 8'h01);
        wr(8'h9b, 8'h80);
        chk({7'h00, cmp_irq}, 8'h00);
        level = 1'b0;
        repeat (20) @(negedge clk);
        rd(8'h9b, 8'h90);
        chk({7'h00, cmp_irq}, 8'h00);
        wr(8'h9d, 8'h10);
        chk({7'h00, cmp_irq}, 8'h01);
        repeat (30) @(negedge clk);
        rd(8'h9b, 8'h90);
        $display("test edges done");
        level = 1'b1;
        repeat (20) @(negedge clk);
        rd(8'h9b, 8'hf0);
        wr(8'h9b, 8'h00);
        repeat (20) @(negedge clk);
        wr(8'h9b, 8'h00);
        rd(8'h9b, 8'h00);
        chk({7'h00, ana.enable}, 8'h00);
        chk({7'h00, cmp_irq}, 8'h00);
        $display("test disable done");
        // A write while the clock enable is low must leave the mux untouched.
        @(negedge clk) clk_en = 1'b0;
        wr(8'h9f, 8'h12);
        @(negedge clk) clk_en = 1'b1;
        rd(8'h9f, 8'hf0);
        chk(ana.neg_pin_sel, 8'h00);
        chk(ana.pos_pin_sel, 8'h01);
        $display("test clock enable done");
        // A second reset in mid-run restores the reset values.
        @(negedge clk) sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        rd(8'h9f, 8'hff);
        rd(8'h9d, 8'h02);
        chk({6'h00, ana.response_mode}, 8'h02);
        chk(ana.neg_pin_sel, 8'h00);
        $display("test reset again done");
        test_done();
    end
endmodule
`default_nettype wire
